// file: test/pad_partner.sv
// Pull-ups and wired-AND partners on the port pins
`timescale 1ns/10ps
`default_nettype none
module pad_partner
  import port_pad_pkg::*;
(
  input  wire logic [N_LINES-1:0] pad_o,
  input  wire logic [N_LINES-1:0] pad_oe,
  input  wire logic [N_LINES-1:0] ext_low,
  output logic      [N_LINES-1:0] pad_i
);
  // Released lines float to the pull-up; a partner may pull low
  assign pad_i = ((pad_oe & pad_o) | ~pad_oe) & ~ext_low;
endmodule : pad_partner
`default_nettype wire

// file: test/port_pad_configuration_tb.sv
// Self-checking bench for the port pad configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module port_pad_configuration_tb import port_pad_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0;
  logic [N_LINES-1:0] line_latch = '0, line_dir = '0, ext_low = '0;
  logic [N_LINES-1:0] pad_i, pad_o, pad_oe, line_read, line_hysteresis, line_open_drain;
  logic [2*N_NIBBLES-1:0] nibble_edge_field, nibble_drive_field;
  logic [N_NIBBLES-1:0] nibble_slow_edge, nibble_edge_reserved, nibble_drive_reserved;
  logic [N_NIBBLES-1:0] nibble_drive_dynamic, nibble_drive_reduced;
  int n_fail = 0, n_tests = 0;
  port_pad_configuration port_pad_configuration_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .line_latch            (line_latch),
    .line_dir              (line_dir),
    .pad_i                 (pad_i),
    .pad_o                 (pad_o),
    .pad_oe                (pad_oe),
    .line_read             (line_read),
    .line_hysteresis       (line_hysteresis),
    .line_open_drain       (line_open_drain),
    .nibble_edge_field     (nibble_edge_field),
    .nibble_drive_field    (nibble_drive_field),
    .nibble_slow_edge      (nibble_slow_edge),
    .nibble_edge_reserved  (nibble_edge_reserved),
    .nibble_drive_dynamic  (nibble_drive_dynamic),
    .nibble_drive_reduced  (nibble_drive_reduced),
    .nibble_drive_reserved (nibble_drive_reserved)
  );
  pad_partner pad_partner_i (
    .pad_o   (pad_o),
    .pad_oe  (pad_oe),
    .ext_low (ext_low),
    .pad_i   (pad_i)
  );
  initial forever #5 pclk = ~pclk;
  // One APB transfer; waits for pready, takes read data and response
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [15:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset;
    for (int i = 0; i < N_POCON; i++) begin
      apb(1'b0, POCON_IDX[i], 16'h0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
    end
    for (int i = 0; i < N_ODP; i++) begin
      apb(1'b0, ODP_IDX[i], 16'h0000, 4'h0);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1'b0, IDX_INPUT_THRESHOLD_SELECT, 16'h0000, 4'h0);
    `CHK(rd, 32'h0000_0000)
  endtask : t_reset
  task automatic t_regs;
    for (int i = 0; i < N_POCON; i++) begin
      apb(1'b1, POCON_IDX[i], 16'hffff, 4'hf);
      apb(1'b0, POCON_IDX[i], 16'h0000, 4'h0);
      `CHK(rd, {16'h0000, POCON_MASK[i]})
      apb(1'b1, POCON_IDX[i], 16'h0000, 4'hf);
    end
    for (int i = 0; i < N_ODP; i++) begin
      apb(1'b1, ODP_IDX[i], 16'hffff, 4'hf);
      apb(1'b0, ODP_IDX[i], 16'h0000, 4'h0);
      `CHK(rd, {16'h0000, ODP_MASK[i]})
      apb(1'b1, ODP_IDX[i], 16'h0000, 4'hf);
    end
    apb(1'b1, 18'h0_0001, 16'hffff, 4'hf);
    `CHK(err, 1'b1)
    apb(1'b1, IDX_INPUT_THRESHOLD_SELECT, 16'h00ff, 4'h2);
    `CHK(err, 1'b0)
    apb(1'b0, IDX_INPUT_THRESHOLD_SELECT, 16'h0000, 4'h0);
    `CHK(rd, 32'h0000_0000)
  endtask : t_regs
  task automatic t_thresh;
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, IDX_INPUT_THRESHOLD_SELECT, 16'h0001 << b, 4'h1);
      @(posedge pclk);
      `CHK(line_hysteresis, (b == 5) ? 64'h0 : (64'h0000_0000_0000_00ff << (8 * b)))
    end
  endtask : t_thresh
  task automatic t_pad;
    apb(1'b1, IDX_INPUT_THRESHOLD_SELECT, 16'h00ff, 4'h1);
    apb(1'b1, ODP_IDX[0], 16'hffff, 4'h3);
    line_latch <= 64'h5555_5555_5555_5555;
    line_dir <= 64'h0000_ffff_ffff_ffff;
    ext_low <= 64'h0001_0000_0000_0004;
    @(posedge pclk);
    @(posedge pclk);
    `CHK(pad_oe, 64'h0000_ffff_ffff_aaaa)
    `CHK(pad_o & pad_oe, 64'h0000_5555_5555_0000)
    `CHK(pad_i, 64'hfffe_5555_5555_5551)
    `CHK(line_read, 64'hfffe_5555_5555_5555)
    ext_low <= '0;
    apb(1'b1, ODP_IDX[0], 16'h0000, 4'h3);
    @(posedge pclk);
    `CHK(pad_oe, 64'h0000_ffff_ffff_ffff)
  endtask : t_pad
  task automatic t_nibble;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, POCON_IDX[0], {8'h00, {4{c[1:0]}}}, 4'h1);
      @(posedge pclk);
      `CHK(nibble_edge_field[3:0], {2{c[1:0]}})
      `CHK({nibble_slow_edge[0], nibble_edge_reserved[0]}, {c == 1, c >= 2})
      `CHK({nibble_drive_dynamic[1], nibble_drive_reduced[1], nibble_drive_reserved[1]},
           {c == 1, c == 2, c == 3})
    end
    apb(1'b1, POCON_IDX[4], 16'h1234, 4'h3);
    apb(1'b1, POCON_IDX[4], 16'hffff, 4'h2);
    @(posedge pclk);
    `CHK({nibble_edge_field[23:16], nibble_drive_field[23:16]}, 16'hfcf1)
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({nibble_edge_field, nibble_drive_field, line_hysteresis}, '0)
  endtask : t_nibble
  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_thresh();
    t_pad();
    t_nibble();
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule : port_pad_configuration_tb
`default_nettype wire

// file: test/port_pad_properties.sv
// Checker for the port pad configuration block
`timescale 1ns/10ps
`default_nettype none
module port_pad_properties
  import port_pad_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [APB_AW-1:0]      paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [N_LINES-1:0]     line_latch,
  input wire logic [N_LINES-1:0]     line_dir,
  input wire logic [N_LINES-1:0]     pad_i,
  input wire logic [N_LINES-1:0]     pad_o,
  input wire logic [N_LINES-1:0]     pad_oe,
  input wire logic [N_LINES-1:0]     line_read,
  input wire logic [N_LINES-1:0]     line_hysteresis,
  input wire logic [N_LINES-1:0]     line_open_drain,
  input wire logic [2*N_NIBBLES-1:0] nibble_edge_field,
  input wire logic [2*N_NIBBLES-1:0] nibble_drive_field,
  input wire logic [N_NIBBLES-1:0]   nibble_slow_edge,
  input wire logic [N_NIBBLES-1:0]   nibble_edge_reserved,
  input wire logic [N_NIBBLES-1:0]   nibble_drive_dynamic,
  input wire logic [N_NIBBLES-1:0]   nibble_drive_reduced,
  input wire logic [N_NIBBLES-1:0]   nibble_drive_reserved
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic input_threshold_select_wr;
  // Accepted write to the threshold register with the low byte enabled
  assign input_threshold_select_wr = psel && penable && pwrite && pstrb[0] && paddr == {IDX_INPUT_THRESHOLD_SELECT, 2'b00};

  property p_pp; (line_dir & ~line_open_drain & ~(pad_oe & ~(pad_o ^ line_latch))) == '0; endproperty
  a_pp: assert property (p_pp) else $error("push/pull line not driving latch");
  property p_od_hi; (line_open_drain & pad_oe & pad_o) == '0; endproperty
  a_od_hi: assert property (p_od_hi) else $error("open drain drove high");
  property p_od_rel; (line_open_drain & line_latch & pad_oe) == '0; endproperty
  a_od_rel: assert property (p_od_rel) else $error("open drain not released");
  property p_read; line_read == ((line_dir & line_latch) | (~line_dir & pad_i)); endproperty
  a_read: assert property (p_read) else $error("line read wrong");
  property p_gap; !line_open_drain[30]; endproperty
  a_gap: assert property (p_gap) else $error("absent line open drain");
  property p_lo; input_threshold_select_wr |=> line_hysteresis[7:0] == {8{$past(pwdata[0])}}; endproperty
  a_lo: assert property (p_lo) else $error("low byte threshold wrong");
  property p_hi; input_threshold_select_wr |=> line_hysteresis[15:8] == {8{$past(pwdata[1])}}; endproperty
  a_hi: assert property (p_hi) else $error("high byte threshold wrong");
  property p_p6; line_hysteresis[47:40] == 8'h00; endproperty
  a_p6: assert property (p_p6) else $error("port without threshold bit");
  property p_slow; nibble_slow_edge[0] == (nibble_edge_field[1:0] == EDGE_SLOW); endproperty
  a_slow: assert property (p_slow) else $error("slow edge decode");
  property p_eres; nibble_edge_reserved[0] == nibble_edge_field[1]; endproperty
  a_eres: assert property (p_eres) else $error("reserved edge decode");
  property p_drv; {nibble_drive_dynamic[0], nibble_drive_reduced[0]} ==
    {nibble_drive_field[1:0] == DRIVE_DYN, nibble_drive_field[1:0] == DRIVE_LOW}; endproperty
  a_drv: assert property (p_drv) else $error("drive decode");
  property p_dres; nibble_drive_reserved[0] == (nibble_drive_field[1:0] == 2'b11); endproperty
  a_dres: assert property (p_dres) else $error("reserved drive decode");
  property p_rst; $rose(presetn) |-> nibble_edge_field == '0 && line_hysteresis == '0; endproperty
  a_rst: assert property (p_rst) else $error("fields not cleared");
endmodule : port_pad_properties
bind port_pad_configuration port_pad_properties port_pad_properties_i (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pstrb                 (pstrb),
  .line_latch            (line_latch),
  .line_dir              (line_dir),
  .pad_i                 (pad_i),
  .pad_o                 (pad_o),
  .pad_oe                (pad_oe),
  .line_read             (line_read),
  .line_hysteresis       (line_hysteresis),
  .line_open_drain       (line_open_drain),
  .nibble_edge_field     (nibble_edge_field),
  .nibble_drive_field    (nibble_drive_field),
  .nibble_slow_edge      (nibble_slow_edge),
  .nibble_edge_reserved  (nibble_edge_reserved),
  .nibble_drive_dynamic  (nibble_drive_dynamic),
  .nibble_drive_reduced  (nibble_drive_reduced),
  .nibble_drive_reserved (nibble_drive_reserved)
);
`default_nettype wire

// file: verilog/pad_line_driver.sv
// One port line pad driver with push/pull or open-drain output
`timescale 1ns/10ps
`default_nettype none
module pad_line_driver (
  input  wire logic out_latch,
  input  wire logic dir_out,
  input  wire logic open_drain,
  input  wire logic pad_i,
  output logic      pad_o,
  output logic      pad_oe,
  output logic      line_read
);

  // ----------------------------------------------------------------
  // Driver
  // ----------------------------------------------------------------
  // Open drain only ever pulls low; a latched one floats the line
  always_comb begin
    pad_o  = open_drain ? 1'b0 : out_latch;
    pad_oe = dir_out & (~open_drain | ~out_latch);
  end

  // Output lines read back the latch, inputs read the pad
  assign line_read = dir_out ? out_latch : pad_i;

endmodule : pad_line_driver
`default_nettype wire

// file: verilog/port_pad_configuration.sv
// Pad configuration registers and per-line pad control for the general purpose ports
`timescale 1ns/10ps
`default_nettype none
module port_pad_configuration
  import port_pad_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [APB_AW-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [N_LINES-1:0]   line_latch,
  input  wire logic [N_LINES-1:0]   line_dir,
  input  wire logic [N_LINES-1:0]   pad_i,
  output logic      [N_LINES-1:0]   pad_o,
  output logic      [N_LINES-1:0]   pad_oe,
  output logic      [N_LINES-1:0]   line_read,
  output logic      [N_LINES-1:0]   line_hysteresis,
  output logic      [N_LINES-1:0]   line_open_drain,
  output logic      [2*N_NIBBLES-1:0] nibble_edge_field,
  output logic      [2*N_NIBBLES-1:0] nibble_drive_field,
  output logic      [N_NIBBLES-1:0] nibble_slow_edge,
  output logic      [N_NIBBLES-1:0] nibble_edge_reserved,
  output logic      [N_NIBBLES-1:0] nibble_drive_dynamic,
  output logic      [N_NIBBLES-1:0] nibble_drive_reduced,
  output logic      [N_NIBBLES-1:0] nibble_drive_reserved
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]              input_threshold_select;
    logic [N_POCON-1:0][15:0] pocon;
    logic [N_ODP-1:0][15:0]   odp;
    logic [31:0]              rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]   idx;
  logic               hit_input_threshold_select;
  logic [N_POCON-1:0] hit_pocon;
  logic [N_ODP-1:0]   hit_odp;
  logic               mapped;
  logic [15:0]        rd_word;
  logic [15:0]        byte_en;
  logic               wr_take;

  assign idx     = paddr[APB_AW-1:2];
  assign byte_en = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Word-aligned match against each register index
  always_comb begin
    hit_input_threshold_select = (idx == IDX_INPUT_THRESHOLD_SELECT);
    for (int k = 0; k < N_POCON; k++) begin
      hit_pocon[k] = (idx == POCON_IDX[k]);
    end
    for (int k = 0; k < N_ODP; k++) begin
      hit_odp[k] = (idx == ODP_IDX[k]);
    end
    mapped = (paddr[1:0] == 2'b00) & (hit_input_threshold_select | (|hit_pocon) | (|hit_odp));
  end

  // Read mux; unimplemented bits and the 8-bit high byte read zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_input_threshold_select) begin
      rd_word = state_reg.input_threshold_select & INPUT_THRESHOLD_SELECT_MASK;
    end
    for (int k = 0; k < N_POCON; k++) begin
      if (hit_pocon[k]) begin
        rd_word = state_reg.pocon[k] & POCON_MASK[k];
      end
    end
    for (int k = 0; k < N_ODP; k++) begin
      if (hit_odp[k]) begin
        rd_word = state_reg.odp[k] & ODP_MASK[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Read data is captured in setup, so access completes at once
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = state_reg.rdata;
  assign wr_take = psel & penable & pwrite & mapped;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (psel & ~penable) begin
      state_next.rdata = (~pwrite & mapped) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
    if (wr_take) begin
      if (hit_input_threshold_select) begin
        state_next.input_threshold_select = ((state_reg.input_threshold_select & ~byte_en) | (pwdata[15:0] & byte_en))
                           & INPUT_THRESHOLD_SELECT_MASK;
      end
      for (int k = 0; k < N_POCON; k++) begin
        if (hit_pocon[k]) begin
          state_next.pocon[k] = ((state_reg.pocon[k] & ~byte_en) | (pwdata[15:0] & byte_en))
                                & POCON_MASK[k];
        end
      end
      for (int k = 0; k < N_ODP; k++) begin
        if (hit_odp[k]) begin
          state_next.odp[k] = ((state_reg.odp[k] & ~byte_en) | (pwdata[15:0] & byte_en))
                              & ODP_MASK[k];
        end
      end
    end
  end

  // Register the whole state; reset selects push/pull, TTL, fast, max drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.input_threshold_select <= INPUT_THRESHOLD_SELECT_RESET;
      for (int k = 0; k < N_POCON; k++) begin
        state_reg.pocon[k] <= POCON_RESET;
      end
      for (int k = 0; k < N_ODP; k++) begin
        state_reg.odp[k] <= ODP_RESET;
      end
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-line open-drain and threshold maps
  // ----------------------------------------------------------------
  // Lines: port 2 [15:0], 3 [31:16], 4 [39:32], 6 [47:40], 7 [55:48], 8 [63:56]
  assign line_open_drain = {state_reg.odp[5][7:0], state_reg.odp[4][7:0],
                            state_reg.odp[3][7:0], state_reg.odp[2][7:0],
                            state_reg.odp[1], state_reg.odp[0]};

  // One threshold bit fans out to each byte it controls; port 6 stays TTL
  assign line_hysteresis = {{8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P8L]}},
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P7L]}},
                            8'h00,
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P4L]}},
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P3H]}},
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P3L]}},
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P2H]}},
                            {8{state_reg.input_threshold_select[INPUT_THRESHOLD_SELECT_P2L]}}};

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  // Threshold select does not reach the driver, so all output modes remain
  for (genvar i = 0; i < N_LINES; i++) begin : g_line
    pad_line_driver u_drv (
      .out_latch  (line_latch[i]),
      .dir_out    (line_dir[i]),
      .open_drain (line_open_drain[i]),
      .pad_i      (pad_i[i]),
      .pad_o      (pad_o[i]),
      .pad_oe     (pad_oe[i]),
      .line_read  (line_read[i])
    );
  end

  // ----------------------------------------------------------------
  // Nibble edge and drive controls
  // ----------------------------------------------------------------
  // Nibbles in order: ports 0L, 0H, 1L, 1H (2 each), 2, 3 (4 each), 4, 6, 7, 8
  logic [NIBBLE_W*N_NIBBLES-1:0] nibble_ctl;

  assign nibble_ctl = {state_reg.pocon[9][7:0], state_reg.pocon[8][7:0],
                       state_reg.pocon[7][7:0], state_reg.pocon[6][7:0],
                       state_reg.pocon[5], state_reg.pocon[4],
                       state_reg.pocon[3][7:0], state_reg.pocon[2][7:0],
                       state_reg.pocon[1][7:0], state_reg.pocon[0][7:0]};

  // Split each nibble into fields and decode the defined codes
  for (genvar n = 0; n < N_NIBBLES; n++) begin : g_nibble
    logic [1:0] edge_f;
    logic [1:0] drive_f;
    assign edge_f  = nibble_ctl[NIBBLE_W*n+EDGE_LSB +: 2];
    assign drive_f = nibble_ctl[NIBBLE_W*n+DRIVE_LSB +: 2];
    assign nibble_edge_field[2*n +: 2]  = edge_f;
    assign nibble_drive_field[2*n +: 2] = drive_f;
    // Reserved edge codes leave the pad in fast mode and are flagged
    assign nibble_slow_edge[n]      = (edge_f == EDGE_SLOW);
    assign nibble_edge_reserved[n]  = (edge_f != EDGE_FAST) & (edge_f != EDGE_SLOW);
    assign nibble_drive_dynamic[n]  = (drive_f == DRIVE_DYN);
    assign nibble_drive_reduced[n]  = (drive_f == DRIVE_LOW);
    assign nibble_drive_reserved[n] = (drive_f != DRIVE_HIGH) & (drive_f != DRIVE_DYN)
                                      & (drive_f != DRIVE_LOW);
  end

endmodule : port_pad_configuration
`default_nettype wire

// file: verilog/port_pad_pkg.sv
// Constants for the port pad configuration block
package port_pad_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_LINES   = 64;
  localparam int N_NIBBLES = 24;
  localparam int N_ODP     = 6;
  localparam int N_POCON   = 10;
  localparam int APB_AW    = 20;
  localparam int IDX_W     = 18;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_INPUT_THRESHOLD_SELECT = 18'h0_f1c4;
  // Order: port 0 low, 0 high, 1 low, 1 high, 2, 3, 4, 6, 7, 8
  localparam logic [IDX_W-1:0] POCON_IDX [N_POCON] = '{
    18'h0_f080, 18'h0_f082, 18'h0_f084, 18'h0_f086, 18'h0_f088,
    18'h0_f08a, 18'h0_f08c, 18'h0_f08e, 18'h0_f090, 18'h0_f092};
  // Order: port 2, 3, 4, 6, 7, 8
  localparam logic [IDX_W-1:0] ODP_IDX [N_ODP] = '{
    18'h0_f0c0, 18'h0_f0c1, 18'h0_f0c2, 18'h0_f0c3, 18'h0_f0c4, 18'h0_f0c5};

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] INPUT_THRESHOLD_SELECT_MASK = 16'h00ff;
  localparam logic [15:0] POCON_MASK [N_POCON] = '{
    16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff,
    16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
  localparam logic [15:0] ODP_MASK [N_ODP] = '{
    16'hffff, 16'hbfff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
  localparam logic [15:0] INPUT_THRESHOLD_SELECT_RESET = 16'h0000;
  localparam logic [15:0] POCON_RESET = 16'h0000;
  localparam logic [15:0] ODP_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Threshold bit positions
  // ----------------------------------------------------------------
  localparam int INPUT_THRESHOLD_SELECT_P2L = 0;
  localparam int INPUT_THRESHOLD_SELECT_P2H = 1;
  localparam int INPUT_THRESHOLD_SELECT_P3L = 2;
  localparam int INPUT_THRESHOLD_SELECT_P3H = 3;
  localparam int INPUT_THRESHOLD_SELECT_P4L = 4;
  localparam int INPUT_THRESHOLD_SELECT_P7L = 6;
  localparam int INPUT_THRESHOLD_SELECT_P8L = 7;

  // ----------------------------------------------------------------
  // Nibble field layout and codes
  // ----------------------------------------------------------------
  localparam int NIBBLE_W  = 4;
  localparam int EDGE_LSB  = 0;
  localparam int DRIVE_LSB = 2;
  localparam logic [1:0] EDGE_FAST  = 2'b00;
  localparam logic [1:0] EDGE_SLOW  = 2'b01;
  localparam logic [1:0] DRIVE_HIGH = 2'b00;
  localparam logic [1:0] DRIVE_DYN  = 2'b01;
  localparam logic [1:0] DRIVE_LOW  = 2'b10;

endpackage : port_pad_pkg
